// ===== hdl/wsb_params.svh
// register offsets, field positions, length limits and the underflow error code of the stream buffer
`ifndef WSB_PARAMS_SVH
`define WSB_PARAMS_SVH
// register byte offsets
`define WSB_CTRL_OFS      12'h000
`define WSB_STATUS_OFS    12'h004
`define WSB_DLEN_OFS      12'h008
`define WSB_FREE_OFS      12'h00c
`define WSB_LARGEST_OFS   12'h010
`define WSB_DATA_OFS      12'h014
`define WSB_ERRCODE_OFS   12'h018
`define WSB_USED_OFS      12'h01c
`define WSB_SBSIZE_OFS    12'h020
// control fields
`define WSB_CTRL_RUN      0
`define WSB_CTRL_ABORT    1
`define WSB_CTRL_OSP      2
`define WSB_CTRL_CPLX     3
`define WSB_CTRL_MODE_LO  4
`define WSB_CTRL_CHAN_LO  8
// status fields
`define WSB_ST_RUN        0
`define WSB_ST_UNDERFLOW  1
`define WSB_ST_OVERWRITE  2
`define WSB_ST_LENERR     3
`define WSB_ST_STARVE     4
// length limits
`define WSB_QUANTUM       2
`define WSB_MIN_LEN       4
`define WSB_MIN_LEN_CPLX  2
// error code reported for a data underflow
`define WSB_UNDERFLOW_CODE 32'hbffa4ac3
`endif

// ===== hdl/wsb_pkg.sv
// types shared by the waveform stream buffer
package wsb_pkg;
   // output modes that may all stream
   typedef enum logic [1:0] {
      WSB_MODE_ARB,
      WSB_MODE_SEQ,
      WSB_MODE_SCRIPT
   } wsb_mode_e;
   // one sample towards the output path
   typedef struct packed {
      logic valid;
      logic [1:0] chan;
      logic signed [15:0] data;
   } wsb_sample_s;
endpackage

// ===== hdl/wsb_stream_buffer.sv
// waveform stream buffer: sample memory, length checks, circular streaming region over apb
//
// What this block does
// RULE_01 - samples stored and forwarded as full signed 16 bits
// RULE_02 - odd sample counts refused on download
// RULE_03 - minimum four samples, two for complex processing
// RULE_04 - fetch lagging output raises underflow, fixed code
// RULE_05 - underflow held until abort or done query
// RULE_06 - largest download equals memory minus used
// RULE_07 - streaming region freed as samples are generated
// RULE_08 - host total length multiple of buffer size
// RULE_09 - overwrite of ungenerated samples rejected, starvation flagged
// RULE_10 - successive write blocks appended contiguously
// RULE_11 - free sample count readable, updated live
// RULE_12 - host preloads buffer before starting
// RULE_13 - host refills near ten percent free
// RULE_14 - interleaved samples routed to channels in rotation
// RULE_15 - streaming works in all three output modes
// RULE_16 - wrapping write and read positions, fill count gives free space
`timescale 1ns/1ps
`include "wsb_params.svh"
module wsb_stream_buffer #(
   parameter int ADDR_W = 10,   // log2 of sample memory depth
   parameter int CHANS = 2      // interleaved output channels
) (
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // output path towards gain, processing and converter
   input wire logic out_tick,
   output wsb_pkg::wsb_sample_s sample_out
);
   localparam int DEPTH = 1 << ADDR_W;

   ////////////////////////////////////////////////////////////////////////////
   // how the block is meant to be used
   //
   // memory map of samples:
   //   the whole sample memory is DEPTH words of 16 bits
   //   stored waveform reservations and the streaming region share it
   //   the used count grows with every accepted reservation
   //   nothing ever gives space back: a full reset is the only way out
   //   (trade-off: no allocator, so no fragmentation logic to verify)
   //
   // streaming region:
   //   always starts at sample zero of the memory
   //   write and read positions both wrap at the region size
   //   the fill count, not the pointers, decides free space
   //   (why: equal pointers mean both empty and full, fill tells them apart)
   //
   // host side:
   //   one data word carries two samples, low half first
   //   the region size is even, so a word never straddles the wrap
   //   a word is refused whole when free samples plus the one leaving this cycle are fewer than two
   //   the host must preload the region before setting run
   //   the host should refill when a small share of the region is free
   //
   // output side:
   //   one sample leaves per out_tick while running and not empty
   //   an empty region on a tick is an underflow and a starvation
   //   channel numbers rotate over the enabled channels only
   //
   // limitations:
   //   pstrb is ignored, partial words are not supported
   //   the output mode is only stored, all modes stream the same way
   //   one tick per cycle at most: the output path is not buffered

   ////////////////////////////////////////////////////////////////////////////
   // elaboration checks
   initial begin
      if (ADDR_W < 2 || ADDR_W > 20) begin
         $error("ADDR_W out of range");
      end
      if (CHANS < 1 || CHANS > 4) begin
         $error("CHANS out of range");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sample memory, kept outside the state struct so it does not need reset
   logic signed [15:0] mem [DEPTH];   // RULE_01

   // all control state of the block
   typedef struct packed {
      logic run;                 // generation running
      logic onboard_signal_processing;                 // onboard_signal_processing enabled
      logic cplx;                // complex sample data
      logic [1:0] mode;          // output mode
      logic [1:0] nchan_m1;      // channels minus one
      logic [ADDR_W:0] sb_size;  // streaming region size in samples
      logic [ADDR_W:0] used;     // occupied samples of whole memory
      logic [ADDR_W:0] fill;     // ungenerated samples in region
      logic [ADDR_W-1:0] wptr;   // write position
      logic [ADDR_W-1:0] rptr;   // read position
      logic [1:0] chan;          // channel of next output sample
      logic underflow;           // sticky data underflow
      logic overwrite;           // sticky rejected write
      logic lenerr;              // sticky refused length
      logic starve;              // sticky host too slow
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      wsb_pkg::wsb_sample_s smp;
   } wsb_state_s;

   wsb_state_s st_reg;
   wsb_state_s st_next;

   // bus decode
   logic acc;      // access phase, answered next cycle
   logic wr;       // write taking effect
   logic rd;       // read taking effect
   logic [ADDR_W:0] dlen;
   logic [ADDR_W:0] min_len;
   logic mem_we;

   // the request is taken in the first access cycle only; the registered
   // pready that follows masks the second access cycle, so a held request
   // is never applied twice (hazard: a data word stored twice)
   // the master must keep psel, penable, address and data until pready
   assign acc = psel && penable && !st_reg.pready;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign dlen = pwdata[ADDR_W:0];
   assign min_len = (st_reg.onboard_signal_processing && st_reg.cplx) ? (ADDR_W+1)'(`WSB_MIN_LEN_CPLX)
                                                : (ADDR_W+1)'(`WSB_MIN_LEN); // RULE_03

   ////////////////////////////////////////////////////////////////////////////
   // next state
   //
   // order of the steps below matters:
   //   1. generation, so a sample read this cycle frees its slot
   //   2. register writes, which may add to the fill count
   //   3. register reads, which report the old state and clear flags
   // a flag set by generation in the same cycle as a status read
   // survives the read: the event wins over the clear
   // the data write counts the sample leaving this cycle as free,
   // so a region with one free sample takes a word in the cycle a sample leaves
   always_comb begin
      logic [ADDR_W:0] free_cnt;
      logic gen;
      free_cnt = '0;
      gen = 1'b0;
      st_next = st_reg;
      st_next.pready = acc;        // one wait state, then a one-cycle answer
      st_next.pslverr = 1'b0;
      st_next.prdata = '0;
      st_next.smp.valid = 1'b0;
      free_cnt = st_reg.sb_size - st_reg.fill;  // RULE_16
      mem_we = 1'b0;

      // generation consumes one sample per tick
      if (st_reg.run && out_tick) begin
         if (st_reg.fill != '0) begin
            gen = 1'b1;
            st_next.smp.valid = 1'b1;
            st_next.smp.data = mem[st_reg.rptr];   // RULE_01
            st_next.smp.chan = st_reg.chan;        // RULE_14
            st_next.chan = (st_reg.chan == st_reg.nchan_m1) ? 2'h0 : st_reg.chan + 2'h1; // RULE_14
            // wrap at region end
            st_next.rptr = (st_reg.rptr == ADDR_W'(st_reg.sb_size - 1'b1)) ? '0
                                                                             : st_reg.rptr + 1'b1; // RULE_16
            st_next.fill = st_reg.fill - 1'b1;     // RULE_07
         end else begin
            st_next.underflow = 1'b1;              // RULE_04
            st_next.starve = 1'b1;                 // RULE_09
         end
      end

      // register writes
      if (wr) begin
         unique case (paddr)
            `WSB_CTRL_OFS: begin
               if (pwdata[`WSB_CTRL_ABORT]) begin
                  st_next.run = 1'b0;
                  st_next.underflow = 1'b0;        // RULE_05
                  st_next.starve = 1'b0;
               end else begin
                  st_next.run = pwdata[`WSB_CTRL_RUN];  // RULE_15
               end
               st_next.onboard_signal_processing = pwdata[`WSB_CTRL_OSP];
               st_next.cplx = pwdata[`WSB_CTRL_CPLX];
               st_next.mode = (pwdata[`WSB_CTRL_MODE_LO +: 2] == 2'h3) ? 2'h0
                                                                         : pwdata[`WSB_CTRL_MODE_LO +: 2]; // RULE_15
               st_next.nchan_m1 = (pwdata[`WSB_CTRL_CHAN_LO +: 2] > 2'(CHANS - 1)) ? 2'(CHANS - 1)
                                                                                  : pwdata[`WSB_CTRL_CHAN_LO +: 2];
               if (!st_reg.run) begin
                  st_next.chan = 2'h0;
               end
            end
            `WSB_DLEN_OFS: begin
               // stored waveform reservation, checked before it takes space
               if (dlen[0] || dlen < min_len || pwdata[31:ADDR_W+1] != '0 ||
                   dlen > (ADDR_W+1)'(DEPTH) - st_reg.used) begin
                  st_next.lenerr = 1'b1;           // RULE_02 RULE_03
                  st_next.pslverr = 1'b1;
               end else begin
                  st_next.used = st_reg.used + dlen; // RULE_06
               end
            end
            `WSB_SBSIZE_OFS: begin
               // region size may change only while stopped; any fill is dropped
               if (st_reg.run || dlen[0] || dlen < min_len || pwdata[31:ADDR_W+1] != '0 ||
                   dlen > (ADDR_W+1)'(DEPTH) - st_reg.used) begin
                  st_next.lenerr = 1'b1;           // RULE_02 RULE_03
                  st_next.pslverr = 1'b1;
               end else begin
                  st_next.sb_size = dlen;          // RULE_07
                  st_next.used = st_reg.used + dlen;
                  st_next.fill = '0;
                  st_next.wptr = '0;
                  st_next.rptr = '0;
               end
            end
            `WSB_DATA_OFS: begin
               // one word carries two samples, keeping the quantum of two
               if ((free_cnt + (gen ? 1'b1 : 1'b0)) < (ADDR_W+1)'(`WSB_QUANTUM) || st_reg.sb_size == '0) begin
                  st_next.overwrite = 1'b1;        // RULE_09
                  st_next.pslverr = 1'b1;
               end else begin
                  mem_we = 1'b1;                   // RULE_10
                  st_next.wptr = (st_reg.wptr + 2'd2 == ADDR_W'(st_reg.sb_size)) ? '0
                                                                                  : st_reg.wptr + 2'd2; // RULE_16
                  st_next.fill = st_next.fill + 2'd2;
               end
            end
            `WSB_STATUS_OFS: begin
               // write one to clear the length and overwrite flags
               if (pwdata[`WSB_ST_OVERWRITE]) begin
                  st_next.overwrite = 1'b0;
               end
               if (pwdata[`WSB_ST_LENERR]) begin
                  st_next.lenerr = 1'b0;
               end
            end
            default: begin
               st_next.pslverr = 1'b1;             // unmapped or read-only
            end
         endcase
      end

      // register reads
      if (rd) begin
         unique case (paddr)
            `WSB_CTRL_OFS: begin
               st_next.prdata = {22'h0, st_reg.nchan_m1, 2'h0, st_reg.mode, st_reg.cplx, st_reg.onboard_signal_processing,
                                 1'b0, st_reg.run};
            end
            `WSB_STATUS_OFS: begin
               // done query reports and then clears the underflow and starve flags
               st_next.prdata = {27'h0, st_reg.starve, st_reg.lenerr, st_reg.overwrite,
                                 st_reg.underflow, st_reg.run};
               // an underflow raised in this very cycle is kept
               st_next.underflow = st_next.underflow & st_reg.run & out_tick & (st_reg.fill == '0); // RULE_05
               st_next.starve = st_next.starve & st_reg.run & out_tick & (st_reg.fill == '0);
            end
            `WSB_ERRCODE_OFS: begin
               st_next.prdata = st_reg.underflow ? `WSB_UNDERFLOW_CODE : 32'h0; // RULE_04
            end
            `WSB_FREE_OFS: begin
               st_next.prdata = 32'(free_cnt);     // RULE_11
            end
            `WSB_LARGEST_OFS: begin
               st_next.prdata = 32'((ADDR_W+1)'(DEPTH) - st_reg.used); // RULE_06
            end
            `WSB_USED_OFS: begin
               st_next.prdata = 32'(st_reg.used);
            end
            `WSB_SBSIZE_OFS: begin
               st_next.prdata = 32'(st_reg.sb_size);
            end
            `WSB_DLEN_OFS, `WSB_DATA_OFS: begin
               st_next.prdata = 32'h0;
            end
            default: begin
               st_next.pslverr = 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // sample memory write, low half first
   // no reset on purpose: a reset memory would cost a clear sequence,
   // and no sample is ever read before the host has written it, since
   // the fill count starts at zero and only data writes raise it
   // the second index cannot leave the region: the write position is
   // always even and the region size is always even
   always_ff @(posedge pclk) begin
      if (mem_we) begin
         mem[st_reg.wptr] <= pwdata[15:0];         // RULE_10
         mem[st_reg.wptr + 1'b1] <= pwdata[31:16];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from flip-flops
   // each answer stands for exactly one cycle; prdata is zero otherwise,
   // so a master that samples late sees zero rather than stale data
   // the sample output is a one-cycle pulse per generated sample
   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign sample_out = st_reg.smp;
endmodule

// ===== testbench/wsb_stream_buffer_chk.sv
// protocol and stream checks for the waveform stream buffer
`timescale 1ns/1ps
`include "wsb_params.svh"
module wsb_stream_buffer_chk #(
   parameter int ADDR_W = 10,
   parameter int CHANS = 2
) (
   // apb side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // output path
   input wire logic out_tick,
   input wire wsb_pkg::wsb_sample_s sample_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // first access cycle, where the slave takes a request
   wire take = psel && penable && !pready;
   wire len_wr = take && pwrite && paddr == `WSB_DLEN_OFS;
   wire rd_done = pready && !pwrite;
   ////////////////////////////////////////////////////////////////
   a_ready_after_take: assert property (take |=> pready) else $error("no answer after take");
   a_ready_one_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
   a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata outside answer");
   a_odd_len_refused: assert property (len_wr && pwdata[0] |=> pslverr) else $error("odd length taken");
   a_short_len_refused: assert property (len_wr && pwdata < 32'h2 |=> pslverr) else $error("short length taken");
   a_errcode_value: assert property (rd_done && paddr == `WSB_ERRCODE_OFS && prdata != 32'h0
      |-> prdata == `WSB_UNDERFLOW_CODE) else $error("wrong error code");
   a_largest_bound: assert property (rd_done && paddr == `WSB_LARGEST_OFS
      |-> prdata <= 32'(1 << ADDR_W)) else $error("largest beyond memory");
   a_sample_needs_tick: assert property (sample_out.valid |-> $past(out_tick)) else $error("sample without tick");
   a_chan_in_range: assert property (sample_out.valid |-> sample_out.chan < CHANS) else $error("bad channel");
   a_unmapped_refused: assert property (take && paddr > `WSB_SBSIZE_OFS |=> pslverr) else $error("unmapped taken");
   // main scenarios seen
   c_sample: cover property (sample_out.valid);
   c_refused: cover property (pslverr);
   c_code: cover property (rd_done && paddr == `WSB_ERRCODE_OFS && prdata != 32'h0);
endmodule
bind wsb_stream_buffer wsb_stream_buffer_chk #(.ADDR_W(ADDR_W), .CHANS(CHANS)) chk_inst (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .out_tick(out_tick),
   .sample_out(sample_out));

// ===== testbench/wsb_sample_sink.sv
// output path model: pulls samples with ticks and keeps what arrives
`timescale 1ns/1ps
module wsb_sample_sink (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // sample path
   output logic out_tick,
   input wire wsb_pkg::wsb_sample_s sample_out
);
   wsb_pkg::wsb_sample_s got[$]; // arrived samples, oldest first
   initial out_tick = 1'b0;
   // whole word kept, so a narrowed sample shows up
   always @(posedge pclk) if (presetn && sample_out.valid) got.push_back(sample_out);
   // n ticks, gap plus one idle cycles after each: gap 0 is prompt, larger is slow
   task automatic pull(input int n, input int gap);
      repeat (n) begin
         @(posedge pclk);
         out_tick <= 1'b1;
         @(posedge pclk);
         out_tick <= 1'b0;
         repeat (gap) @(posedge pclk);
      end
      repeat (2) @(posedge pclk);
   endtask
endmodule

// ===== testbench/wsb_stream_buffer_bench.sv
// self-checking bench for the waveform stream buffer
`timescale 1ns/1ps
`include "wsb_params.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
   $display("Error at %0t: got %h expected %h", $time, a, b); end end
module wsb_stream_buffer_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, out_tick;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   wsb_pkg::wsb_sample_s sample_out, s;
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;
   // small memory keeps counts short
   wsb_stream_buffer #(.ADDR_W(4), .CHANS(2)) wsb_stream_buffer_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .out_tick(out_tick), .sample_out(sample_out));
   wsb_sample_sink wsb_sample_sink_inst (.pclk(pclk), .presetn(presetn), .out_tick(out_tick),
      .sample_out(sample_out));
   always #20 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////
   // negative samples so a lost sign bit shows
   function automatic logic [15:0] val(input int i);
      return 16'hf000 + 16'(i);
   endfunction
   function automatic logic [31:0] word(input int j);
      return {val(2 * j + 1), val(2 * j)};
   endfunction
   // one apb transfer; d is write data or expected read data
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      `CHK(pslverr, e)
      if (!w && !e) `CHK(prdata, d)
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // channel rotation over the global sample index
   task automatic samples(input int n, input int first);
      for (int i = first; i < first + n; i++) begin
         s = wsb_sample_sink_inst.got.pop_front();
         `CHK(s, {1'b1, 2'(i % 2), val(i)})
      end
   endtask
   task automatic wrap_up();
      if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 4000) begin
         fail_count++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      acc(0, `WSB_LARGEST_OFS, 32'h10, 0);
      acc(0, `WSB_FREE_OFS, 32'h0, 0);
      acc(1, `WSB_DLEN_OFS, 32'h7, 1);
      acc(1, `WSB_DLEN_OFS, 32'h2, 1);
      acc(1, `WSB_DLEN_OFS, 32'h4, 0);
      acc(1, `WSB_CTRL_OFS, 32'hc, 0);
      acc(1, `WSB_DLEN_OFS, 32'h2, 0);
      acc(1, `WSB_SBSIZE_OFS, 32'h8, 0);
      acc(0, `WSB_LARGEST_OFS, 32'h2, 0);
      acc(1, `WSB_DLEN_OFS, 32'h4, 1);
      acc(0, `WSB_FREE_OFS, 32'h8, 0);
      for (int j = 0; j < 4; j++) acc(1, `WSB_DATA_OFS, word(j), 0);
      acc(1, `WSB_DATA_OFS, word(4), 1);
      acc(1, `WSB_FREE_OFS, 32'h0, 1);
      acc(0, 12'h040, 32'h0, 1);
      acc(1, `WSB_STATUS_OFS, 32'hc, 0);
      acc(0, `WSB_STATUS_OFS, 32'h0, 0);
      // each output mode streams; slower pulls in later modes
      for (int m = 0; m < 3; m++) begin
         acc(1, `WSB_CTRL_OFS, 32'h10d | (32'(m) << 4), 0);
         wsb_sample_sink_inst.pull(2, m);
         samples(2, 2 * m);
         acc(0, `WSB_FREE_OFS, 32'h2, 0);
         acc(1, `WSB_DATA_OFS, word(4 + m), 0);
      end
      acc(0, `WSB_CTRL_OFS, 32'h12d, 0);
      acc(0, `WSB_USED_OFS, 32'he, 0);
      acc(0, `WSB_SBSIZE_OFS, 32'h8, 0);
      // one more refill once some space is free: 16 samples, twice the region
      wsb_sample_sink_inst.pull(2, 0);
      samples(2, 6);
      acc(0, `WSB_FREE_OFS, 32'h2, 0);
      acc(1, `WSB_DATA_OFS, word(7), 0);
      // drain past empty: refills wrapped in order, then underflow
      wsb_sample_sink_inst.pull(9, 0);
      samples(8, 8);
      acc(0, `WSB_ERRCODE_OFS, `WSB_UNDERFLOW_CODE, 0);
      acc(0, `WSB_STATUS_OFS, 32'h13, 0);
      acc(0, `WSB_STATUS_OFS, 32'h1, 0);
      wsb_sample_sink_inst.pull(1, 0);
      acc(1, `WSB_CTRL_OFS, 32'h2, 0);
      acc(0, `WSB_STATUS_OFS, 32'h0, 0);
      wrap_up();
   end
endmodule
